//--- rtl/qdl_pkg.sv
// Package for the quad converter serial word loader.
// Shared by the loader top, its checker, the host model and the bench.
package qdl_pkg;

    // ------------------------------------------------------------
    // Word layout
    // ------------------------------------------------------------
    localparam int WORD_BITS  = 16;
    localparam int CH_MSB     = 15;
    localparam int CH_LSB     = 14;
    localparam int PD_POS     = 13;
    localparam int LOAD_POS   = 12;
    localparam int FIELD_BITS = 12;
    localparam int NUM_CH     = 4;
    localparam int CH_BITS    = 2;

    // ------------------------------------------------------------
    // Resolution variant: 8, 10 or 12; code is the top of the field
    // ------------------------------------------------------------
    localparam int RES_BITS   = 12;
    localparam int TAP_COUNT  = 1 << RES_BITS;
    localparam int CNT_BITS   = 5;
    localparam logic [CNT_BITS-1:0] LAST_BIT = 5'h0F;
    localparam logic [CNT_BITS-1:0] FULL_CNT = 5'h10;

    // ------------------------------------------------------------
    // Channel codes and reset values
    // ------------------------------------------------------------
    localparam logic [CH_BITS-1:0] CH_A = 2'h0;
    localparam logic [CH_BITS-1:0] CH_B = 2'h1;
    localparam logic [CH_BITS-1:0] CH_C = 2'h2;
    localparam logic [CH_BITS-1:0] CH_D = 2'h3;
    localparam logic [RES_BITS-1:0] CODE_RST = 12'h000;
    localparam logic                PD_RST   = 1'b0;

    // ------------------------------------------------------------
    // Link timing
    // ------------------------------------------------------------
    localparam int SCLK_MAX_MHZ = 30;
    localparam int SYS_MHZ      = 25;

    typedef struct packed {
        logic [CH_BITS-1:0]    chan;
        logic                  low_power_select_n;
        logic                  load_all_outputs_n;
        logic [FIELD_BITS-1:0] field;
    } qdl_word_t;

    typedef enum logic [1:0] {
        QDL_IDLE  = 2'b00,
        QDL_SHIFT = 2'b01,
        QDL_DONE  = 2'b11
    } qdl_frame_t;

endpackage

//--- rtl/qdl_word_buf.sv
// Two-entry word buffer with valid and ready on both sides.
// Assumes one clock and the system reset; full and empty are exact.
`timescale 1ns/1ns
module qdl_word_buf #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 2
) (
    // Clock and reset
    input  wire logic             clk_sys_i,
    input  wire logic             nrst_i,
    // Fill side
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    // Drain side
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW-1:0]    wr_q;
    logic [PW-1:0]    rd_q;
    logic [PW:0]      used_q;
    logic             push;
    logic             pop;

    assign in_ready_o  = (used_q != (PW+1)'(DEPTH));
    assign out_valid_o = (used_q != '0);
    assign out_data_o  = mem_q[rd_q];
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_valid_o & out_ready_i;

    always_ff @(posedge clk_sys_i) begin
        if (push) begin
            mem_q[wr_q] <= in_data_i;
        end
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wr_q   <= '0;
            rd_q   <= '0;
            used_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == PW'(DEPTH - 1)) ? '0 : wr_q + PW'(1);
            end
            if (pop) begin
                rd_q <= (rd_q == PW'(DEPTH - 1)) ? '0 : rd_q + PW'(1);
            end
            used_q <= used_q + (PW+1)'(push) - (PW+1)'(pop);
        end
    end

endmodule // qdl_word_buf

//--- rtl/qdl_loader.sv
// Serial word loader: shift register on the link clock, decode and
// double-buffered code registers on the system clock.
// Assumes the host frames 16 bits per select-low period.
`timescale 1ns/1ns

// Contract
// - A 16-bit shift register collects each whole word before use.
// - Word holds four control bits, then an 8, 10 or 12 bit code.
// - Word arrives MSB first, bit 15 first, shifted in that order.
// - First two bits pick the channel, A through D.
// - Bit 13 chooses power-down or normal operation.
// - Bit 12 controls when output registers and outputs update.
// - After reset: normal operation, every channel at zero code.
// - Reset zeroes input and output registers until a valid write.
// - Code is unsigned straight binary over the variant's full range.
// - Each channel's output code closes exactly one string tap.
// - Power-down turns all four channels off, outputs high impedance.
// - Select low starts a frame; 16 falling clock edges shift data.
// - Select high before bit 16 discards the partial word.
// - Channel 00..11 is A..D; bit values 0 mean power-down, load all.
// - Update bit 1 writes only the input register, outputs unchanged.
module qdl_loader
(
    // System clock and reset
    input  wire logic                                clk_sys_i,
    input  wire logic                                nrst_i,
    // Serial link
    input  wire logic                                sclk_i,
    input  wire logic                                sync_n_i,
    input  wire logic                                din_i,
    // Output stall
    input  wire logic                                out_hold_i,
    // Channel codes and taps
    output logic [qdl_pkg::NUM_CH-1:0][qdl_pkg::RES_BITS-1:0]  channel_code_o,
    output logic [qdl_pkg::NUM_CH-1:0][qdl_pkg::TAP_COUNT-1:0] channel_tap_o,
    output logic [qdl_pkg::NUM_CH-1:0]               channel_output_en_o,
    // Status
    output logic                                     low_power_o,
    output logic                                     word_seen_o,
    output qdl_pkg::qdl_word_t                       last_word_o,
    output logic                                     buf_full_o
);
    import qdl_pkg::*;

    // ------------------------------------------------------------
    // Decoding helpers
    // ------------------------------------------------------------
    function automatic logic [RES_BITS-1:0] take_code(input logic [FIELD_BITS-1:0] f);
        take_code = f[FIELD_BITS-1 -: RES_BITS];
    endfunction

    function automatic logic [TAP_COUNT-1:0] one_tap(input logic [RES_BITS-1:0] c);
        logic [TAP_COUNT-1:0] t;
        t    = '0;
        t[c] = 1'b1;
        one_tap = t;
    endfunction

    function automatic logic [NUM_CH-1:0] chan_hit(input logic [CH_BITS-1:0] c);
        logic [NUM_CH-1:0] h;
        h    = '0;
        h[c] = 1'b1;
        chan_hit = h;
    endfunction

    // ------------------------------------------------------------
    // Link domain: frame state and shift register
    // ------------------------------------------------------------
    logic                  frame_rst_n;
    logic [WORD_BITS-1:0]  shift_q;
    logic [CNT_BITS-1:0]   bit_cnt_q;
    qdl_frame_t            frame_q;
    logic [WORD_BITS-1:0]  held_word_q;
    logic                  word_tgl_q;
    logic [WORD_BITS-1:0]  shift_d;
    logic                  held_free;

    // Frame logic cleared while select is high; partial words die here
    assign frame_rst_n = nrst_i & ~sync_n_i;
    assign shift_d     = {shift_q[WORD_BITS-2:0], din_i};

    always_ff @(negedge sclk_i or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            frame_q <= QDL_IDLE;
        end else begin
            case (frame_q)
                QDL_IDLE: begin
                    frame_q <= QDL_SHIFT;
                end
                QDL_SHIFT: begin
                    if (bit_cnt_q == LAST_BIT) begin
                        frame_q <= QDL_DONE;
                    end
                end
                QDL_DONE: begin
                    frame_q <= QDL_DONE;
                end
                default: begin
                    frame_q <= QDL_IDLE;
                end
            endcase
        end
    end

    always_ff @(negedge sclk_i or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            bit_cnt_q <= '0;
            shift_q   <= '0;
        end else if (bit_cnt_q != FULL_CNT) begin
            bit_cnt_q <= bit_cnt_q + CNT_BITS'(1);
            shift_q   <= shift_d;
        end
    end

    // Only a complete word is handed over
    // A word done before the last one was taken is dropped, never torn
    always_ff @(negedge sclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            held_word_q <= '0;
            word_tgl_q  <= 1'b0;
        end else if (frame_q == QDL_SHIFT && bit_cnt_q == LAST_BIT && held_free) begin
            held_word_q <= shift_d;
            word_tgl_q  <= ~word_tgl_q;
        end
    end

    // ------------------------------------------------------------
    // Crossing: toggle through three flops, word held stable
    // ------------------------------------------------------------
    logic tgl_s1_q;
    logic tgl_s2_q;
    logic tgl_s3_q;
    logic tgl_ack_q;
    logic new_word;

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tgl_s1_q <= 1'b0;
            tgl_s2_q <= 1'b0;
            tgl_s3_q <= 1'b0;
        end else begin
            tgl_s1_q <= word_tgl_q;
            tgl_s2_q <= tgl_s1_q;
            tgl_s3_q <= tgl_s2_q;
        end
    end

    // Held word is stable for a whole frame after the toggle settles
    assign new_word = (tgl_s2_q == tgl_s3_q) && (tgl_s3_q != tgl_ack_q);

    // ------------------------------------------------------------
    // Word buffer
    // ------------------------------------------------------------
    logic      buf_in_ready;
    logic      buf_out_valid;
    logic      buf_out_ready;
    qdl_word_t buf_out_word;
    logic      take_word;

    assign buf_out_ready = ~out_hold_i;
    assign take_word     = buf_out_valid & buf_out_ready;

    // Full buffer leaves the toggle unacknowledged; host must slow down
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tgl_ack_q <= 1'b0;
        end else if (new_word && buf_in_ready) begin
            tgl_ack_q <= tgl_s3_q;
        end
    end

    // ------------------------------------------------------------
    // Acknowledge back into the link domain
    // ------------------------------------------------------------
    logic ack_s1_q;
    logic ack_s2_q;
    logic ack_s3_q;

    // Link clock runs only inside frames; the next frame's first
    // three edges carry the acknowledge across before its bit 16
    always_ff @(negedge sclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ack_s1_q <= 1'b0;
            ack_s2_q <= 1'b0;
            ack_s3_q <= 1'b0;
        end else begin
            ack_s1_q <= tgl_ack_q;
            ack_s2_q <= ack_s1_q;
            ack_s3_q <= ack_s2_q;
        end
    end

    // Held word may change only once the system side has taken it
    assign held_free = (ack_s2_q == ack_s3_q) && (ack_s3_q == word_tgl_q);

    qdl_word_buf #(
        .WIDTH (WORD_BITS),
        .DEPTH (2)
    ) u_buf (
        .clk_sys_i   (clk_sys_i),
        .nrst_i      (nrst_i),
        .in_valid_i  (new_word),
        .in_ready_o  (buf_in_ready),
        .in_data_i   (held_word_q),
        .out_valid_o (buf_out_valid),
        .out_ready_i (buf_out_ready),
        .out_data_o  (buf_out_word)
    );

    // ------------------------------------------------------------
    // Decode of the word at the buffer head
    // ------------------------------------------------------------
    logic [NUM_CH-1:0]   hit;
    logic [RES_BITS-1:0] new_code;
    logic                load_all;

    // Channel from the first two bits
    // 00 A, 01 B, 10 C, 11 D
    assign hit      = chan_hit(buf_out_word.chan);
    assign new_code = take_code(buf_out_word.field);
    // Bit 12 low loads all outputs
    assign load_all = ~buf_out_word.load_all_outputs_n;

    // ------------------------------------------------------------
    // Power-down control
    // ------------------------------------------------------------
    logic pd_q;

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pd_q <= PD_RST;
        end else if (take_word) begin
            pd_q <= ~buf_out_word.low_power_select_n;
        end
    end

    assign low_power_o = pd_q;

    // ------------------------------------------------------------
    // Per-channel input and output code registers
    // ------------------------------------------------------------
    logic [NUM_CH-1:0][RES_BITS-1:0] in_code_q;
    logic [NUM_CH-1:0][RES_BITS-1:0] out_code_q;
    logic [NUM_CH-1:0]               fresh_q;

    for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
        logic [RES_BITS-1:0] in_code_d;
        logic                load_out;

        assign in_code_d = hit[ch] ? new_code : in_code_q[ch];
        // Unchanged inputs skip the load to avoid needless glitches
        assign load_out  = take_word && load_all && (hit[ch] || fresh_q[ch]);

        // Cleared at reset until a valid write
        always_ff @(posedge clk_sys_i or negedge nrst_i) begin
            if (!nrst_i) begin
                in_code_q[ch] <= CODE_RST;
            end else if (take_word && hit[ch]) begin
                in_code_q[ch] <= new_code;
            end
        end

        always_ff @(posedge clk_sys_i or negedge nrst_i) begin
            if (!nrst_i) begin
                fresh_q[ch] <= 1'b0;
            end else if (load_out) begin
                fresh_q[ch] <= 1'b0;
            end else if (take_word && hit[ch]) begin
                fresh_q[ch] <= 1'b1;
            end
        end

        always_ff @(posedge clk_sys_i or negedge nrst_i) begin
            if (!nrst_i) begin
                out_code_q[ch] <= CODE_RST;
            end else if (load_out) begin
                out_code_q[ch] <= in_code_d;
            end
        end

        assign channel_code_o[ch] = out_code_q[ch];

        // --------------------------------------------------------
        // Tap select, one-hot and wide for the string switches
        // --------------------------------------------------------
        // One tap closed per channel
        always_ff @(posedge clk_sys_i or negedge nrst_i) begin
            if (!nrst_i) begin
                channel_tap_o[ch] <= one_tap(CODE_RST);
            end else if (load_out) begin
                channel_tap_o[ch] <= one_tap(in_code_d);
            end
        end

        // --------------------------------------------------------
        // Output enables follow the power bit of every word
        // --------------------------------------------------------
        // All channels off together
        always_ff @(posedge clk_sys_i or negedge nrst_i) begin
            if (!nrst_i) begin
                channel_output_en_o[ch] <= ~PD_RST;
            end else if (take_word) begin
                channel_output_en_o[ch] <= buf_out_word.low_power_select_n;
            end
        end
    end

    // ------------------------------------------------------------
    // Status
    // ------------------------------------------------------------
    // Whole word kept for inspection
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            last_word_o <= '0;
            word_seen_o <= 1'b0;
        end else begin
            word_seen_o <= take_word;
            if (take_word) begin
                last_word_o <= buf_out_word;
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            buf_full_o <= 1'b0;
        end else begin
            buf_full_o <= ~buf_in_ready;
        end
    end

endmodule // qdl_loader

//--- verif/qdl_loader_monitor.sv
// Checker for the serial word loader, system clock domain.
// Assumes it is bound to qdl_loader and sees only its ports.
`timescale 1ns/1ns
module qdl_loader_monitor (
    // Clock and reset
    input wire logic                                                clk_sys_i,
    input wire logic                                                nrst_i,
    // Observed outputs
    input wire logic [qdl_pkg::NUM_CH-1:0][qdl_pkg::RES_BITS-1:0]  channel_code_o,
    input wire logic [qdl_pkg::NUM_CH-1:0][qdl_pkg::TAP_COUNT-1:0] channel_tap_o,
    input wire logic [qdl_pkg::NUM_CH-1:0]                         channel_output_en_o,
    input wire logic                                                low_power_o,
    input wire logic                                                word_seen_o,
    input wire qdl_pkg::qdl_word_t                                  last_word_o
);
    import qdl_pkg::*;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!nrst_i);
    logic seen_q;
    logic tap_ok;
    // Stays low until the first applied word
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) seen_q <= 1'b0;
        else if (word_seen_o) seen_q <= 1'b1;
    end
    always_comb begin
        tap_ok = 1'b1;
        for (int i = 0; i < NUM_CH; i++) begin
            if (channel_tap_o[i] != ({{(TAP_COUNT-1){1'b0}}, 1'b1} << channel_code_o[i])) tap_ok = 1'b0;
        end
    end
    property p_tap; tap_ok; endproperty
    a_tap: assert property (p_tap)
        else $error("tap select differs from code");
    property p_pd_off; channel_output_en_o == (low_power_o ? 4'h0 : 4'hF); endproperty
    a_pd_off: assert property (p_pd_off)
        else $error("output enables disagree with power mode");
    property p_pd_bit; word_seen_o |-> low_power_o == !last_word_o.low_power_select_n; endproperty
    a_pd_bit: assert property (p_pd_bit)
        else $error("power mode does not follow word");
    property p_load;
        word_seen_o && !last_word_o.load_all_outputs_n |-> channel_code_o[last_word_o.chan] == last_word_o.field;
    endproperty
    a_load: assert property (p_load)
        else $error("addressed output code not loaded");
    property p_keep; word_seen_o && last_word_o.load_all_outputs_n |-> channel_code_o == $past(channel_code_o, 2); endproperty
    a_keep: assert property (p_keep)
        else $error("output codes changed without load");
    property p_rst_code; !seen_q && !word_seen_o |-> $past(channel_code_o) == '0; endproperty
    a_rst_code: assert property (p_rst_code)
        else $error("output code nonzero before first word");
    property p_rst_mode; !seen_q && !word_seen_o |-> !$past(low_power_o) && $past(channel_output_en_o) == 4'hF; endproperty
    a_rst_mode: assert property (p_rst_mode)
        else $error("not in normal operation after reset");
    property p_change; $changed(channel_code_o) |-> word_seen_o; endproperty
    a_change: assert property (p_change)
        else $error("output code changed with no word");
endmodule // qdl_loader_monitor

bind qdl_loader qdl_loader_monitor i_mon (
    .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .channel_code_o(channel_code_o),
    .channel_tap_o(channel_tap_o), .channel_output_en_o(channel_output_en_o),
    .low_power_o(low_power_o), .word_seen_o(word_seen_o), .last_word_o(last_word_o)
);

//--- verif/qdl_host_model.sv
// Host serial controller model for the loader link.
// Assumes the bench calls send; link clock idles high outside frames.
`timescale 1ns/1ns
module qdl_host_model (
    // Serial link
    output logic sclk_o,
    output logic sync_n_o,
    output logic din_o
);
    import qdl_pkg::*;
    // 48 ns period, under 30 MHz
    localparam int HALF_NS = 24;
    initial begin
        sclk_o = 1'b1;
        sync_n_o = 1'b1;
        din_o = 1'b0;
    end
    task automatic send(input logic [15:0] word, input int edges);
        sync_n_o = 1'b0;
        for (int i = 0; i < edges; i++) begin
            // bit 15 first, junk past bit 0
            din_o = (i < WORD_BITS) ? word[WORD_BITS-1-i] : ~din_o;
            #HALF_NS sclk_o = 1'b0;
            #HALF_NS sclk_o = 1'b1;
        end
        sync_n_o = 1'b1;
        // Released data line must not look stable
        din_o = ~din_o;
    endtask
endmodule // qdl_host_model

//--- verif/qdl_loader_tb.sv
// Self-checking bench for the serial word loader.
// Assumes qdl_host_model drives the link and the monitor is bound.
`timescale 1ns/1ns
module qdl_loader_tb;
    import qdl_pkg::*;
    logic                              clk_sys_i;
    logic                              nrst_i;
    logic                              sclk;
    logic                              sync_n;
    logic                              din;
    logic                              out_hold;
    logic [NUM_CH-1:0][RES_BITS-1:0]   code;
    logic [NUM_CH-1:0][TAP_COUNT-1:0]  tap;
    logic [NUM_CH-1:0]                 en;
    logic                              low_power;
    logic                              word_seen;
    logic                              buf_full;
    qdl_word_t                         last_word;
    int                                errors = 0;
    int                                samples_checked = 0;
    int                                seen_cnt = 0;
    logic [RES_BITS-1:0]               codes [4] = '{12'hFFF, 12'h001, 12'h800, 12'h7FF};
    logic [15:0]                       w;

    qdl_host_model i_host (.sclk_o(sclk), .sync_n_o(sync_n), .din_o(din));
    qdl_loader i_dut (
        .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .sclk_i(sclk), .sync_n_i(sync_n), .din_i(din),
        .out_hold_i(out_hold), .channel_code_o(code), .channel_tap_o(tap), .channel_output_en_o(en),
        .low_power_o(low_power), .word_seen_o(word_seen), .last_word_o(last_word), .buf_full_o(buf_full)
    );

    initial clk_sys_i = 1'b0;
    always #20 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i) if (word_seen === 1'b1) seen_cnt++;

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Sends a frame and expects n applied words within the wait
    task automatic wr(input logic [15:0] wd, input int edges, input int n);
        int base;
        base = seen_cnt;
        i_host.send(wd, edges);
        for (int k = 0; k < 30; k++) begin
            @(posedge clk_sys_i);
            if (n > 0 && seen_cnt >= base + n) break;
        end
        #1;
        chk(16'(seen_cnt - base), 16'(n));
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        for (int c = 0; c < NUM_CH; c++) begin
            chk(16'(code[c]), 16'h0000);
            chk(16'(tap[c][0]), 16'h0001);
        end
        chk(16'(en), 16'h000F);
        chk(16'(low_power), 16'h0000);
        $display("t_reset done");
    endtask
    task automatic t_channels;
        for (int c = 0; c < NUM_CH; c++) begin
            w = {2'(c), 1'b1, 1'b0, codes[c]};
            wr(w, 16, 1);
            chk(last_word, w);
            chk(16'(code[c]), 16'(codes[c]));
            chk(16'(tap[c][codes[c]]), 16'h0001);
        end
        $display("t_channels done");
    endtask
    task automatic t_hold;
        w = {CH_A, 1'b1, 1'b1, 12'h123};
        wr(w, 16, 1);
        chk(16'(code[0]), 16'h0FFF);
        wr({CH_B, 1'b1, 1'b0, 12'h456}, 16, 1);
        chk(16'(code[0]), 16'h0123);
        chk(16'(code[1]), 16'h0456);
        $display("t_hold done");
    endtask
    task automatic t_power;
        wr({CH_C, 1'b0, 1'b1, 12'hABC}, 16, 1);
        chk(16'(low_power), 16'h0001);
        chk(16'(en), 16'h0000);
        chk(16'(code[2]), 16'h0800);
        wr({CH_C, 1'b1, 1'b1, 12'hABC}, 16, 1);
        chk(16'(en), 16'h000F);
        $display("t_power done");
    endtask
    task automatic t_abort;
        w = last_word;
        wr({CH_D, 1'b1, 1'b0, 12'h055}, 15, 0);
        chk(last_word, w);
        chk(16'(code[3]), 16'h07FF);
        wr({CH_D, 1'b1, 1'b0, 12'h3C3}, 16, 1);
        chk(16'(code[3]), 16'h03C3);
        wr({CH_A, 1'b1, 1'b0, 12'h5A5}, 21, 1);
        chk(16'(code[0]), 16'h05A5);
        $display("t_abort done");
    endtask
    task automatic t_stall;
        @(posedge clk_sys_i);
        out_hold <= 1'b1;
        wr({CH_B, 1'b1, 1'b1, 12'h111}, 16, 0);
        w = {CH_C, 1'b1, 1'b1, 12'h222};
        wr(w, 16, 0);
        chk(16'(buf_full), 16'h0001);
        @(posedge clk_sys_i);
        out_hold <= 1'b0;
        repeat (12) @(posedge clk_sys_i);
        #1;
        chk(last_word, w);
        chk(16'(buf_full), 16'h0000);
        chk(16'(code[1]), 16'h0456);
        $display("t_stall done");
    endtask

    initial begin
        nrst_i = 1'b0;
        out_hold = 1'b0;
        repeat (2) @(posedge clk_sys_i);
        nrst_i <= 1'b1;
        @(posedge clk_sys_i);
        #7;
        t_reset();
        t_channels();
        t_hold();
        t_power();
        t_abort();
        t_stall();
        stop_test();
    end
    // Tests take about 17 us; the limit leaves wide margin
    initial begin
        #100000;
        errors++;
        stop_test();
    end
endmodule // qdl_loader_tb
